//--- hw/capture_timer.sv
// 16-bit capture/compare timer with its register file
// assumes events and debug halt come from logic on i_clk
`default_nettype none
module capture_timer #(
  parameter int CNT_W = 16 // counter width, the byte map needs 16
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire tmr_pkg::addr_t i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire tmr_pkg::data_t i_avs_writedata,
  input wire tmr_pkg::be_t i_avs_byteenable,
  output tmr_pkg::data_t o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_event,
  input wire logic i_debug_halt,
  output logic o_run,
  output logic o_irq
);
  import tmr_pkg::*;

  // ==========================================================
  // elaboration check
  if (CNT_W != 16) begin : g_width_check
    $error("capture_timer: CNT_W must be 16");
  end

  // ==========================================================
  // storage
  cfg_t cfg_r; // software configuration
  logic [CNT_W-1:0] count_value_r; // running count
  logic [CNT_W-1:0] compare_capture_value_r; // compare/capture value
  logic [7:0] latch_r; // shared high-byte latch
  logic catch_irq_flag_r; // sticky catch flag
  logic evt_prev_r; // last sampled event level
  seq_t seq_r; // run sequence of armed modes
  logic wait_r; // waitrequest flop
  data_t rdata_r; // read data flop
  logic run_r; // run status flop
  logic irq_r; // interrupt flop

  // ==========================================================
  // bus decode
  logic acc; // request taken this edge
  logic wr_acc; // write taken
  logic rd_acc; // read taken
  logic rd_load; // read mux loads this edge
  logic [7:0] wbyte; // byte lane 0 of write data

  // a request is taken on the edge where waitrequest is seen low
  assign acc = (i_avs_read | i_avs_write) & ~wait_r;
  assign wr_acc = acc & i_avs_write & i_avs_byteenable[0];
  assign rd_acc = acc & i_avs_read;
  // same edge as the read mux, so low and high byte are one snapshot
  assign rd_load = wait_r & i_avs_read;
  assign wbyte = i_avs_writedata[7:0];

  // per-register write strobes
  logic wr_cnt_lo; // count low commit
  logic wr_compare_capture_value_lo; // compare low commit
  logic wr_latch; // any write that loads the latch
  assign wr_cnt_lo = wr_acc & (i_avs_address == IDX_COUNT_LO);
  assign wr_compare_capture_value_lo = wr_acc & (i_avs_address == IDX_COMPARE_CAPTURE_VALUE_LO);
  assign wr_latch = wr_acc & ((i_avs_address == IDX_HIGH_LATCH)
    | (i_avs_address == IDX_COUNT_HI) | (i_avs_address == IDX_COMPARE_CAPTURE_VALUE_HI));

  // ==========================================================
  // timing qualifiers
  logic active; // counter clock allowed this cycle
  logic ev_pos; // rising event level
  logic ev_neg; // falling event level
  logic ev_first; // edge of the selected polarity
  logic ev_other; // edge of the opposite polarity
  logic ev_ok; // events honoured

  // debug halt freezes the counter and deafens it to events
  assign active = cfg_r.enable & (cfg_r.debug_run | ~i_debug_halt);
  assign ev_ok = active & cfg_r.event_input_enable;
  assign ev_pos = i_event & ~evt_prev_r;
  assign ev_neg = ~i_event & evt_prev_r;
  assign ev_first = ev_ok & (cfg_r.edge_sel ? ev_neg : ev_pos);
  assign ev_other = ev_ok & (cfg_r.edge_sel ? ev_pos : ev_neg);

  // ==========================================================
  // mode decode
  logic counting; // counter advances this cycle
  logic top_full; // full count equals top
  logic top_low; // low byte equals waveform period
  act_t act; // capture, clear and flag requests
  seq_t seq_nxt; // next run sequence

  assign top_full = (count_value_r == compare_capture_value_r);
  assign top_low = (count_value_r[7:0] == compare_capture_value_r[7:0]);

  // one case per counter mode; only one edge acts per cycle
  always_comb begin
    act = '0;
    seq_nxt = seq_r;
    counting = 1'b0;
    case (cfg_r.mode)
      MODE_PERIODIC: begin
        counting = active;
        // wrap at top and flag
        if (active && top_full) begin
          act.flag = 1'b1;
          act.clr = 1'b1;
        end
      end
      MODE_TIMEOUT: begin
        counting = active & (seq_r == ST_RUN);
        // start on selected edge, stop on the other
        if (ev_first && seq_r == ST_IDLE) begin
          seq_nxt = ST_RUN;
          act.clr = 1'b1;
        end else if (ev_other && seq_r == ST_RUN) begin
          seq_nxt = ST_IDLE;
        end else if (counting && top_full) begin
          act.flag = 1'b1;
          act.clr = 1'b1;
        end
      end
      MODE_CAPTURE: begin
        counting = active;
        // snapshot count on event
        if (ev_first) begin
          act.cap = 1'b1;
          act.flag = 1'b1;
        end
      end
      MODE_FREQ: begin
        counting = active;
        // snapshot, then restart from zero
        if (ev_first) begin
          act.cap = 1'b1;
          act.clr = 1'b1;
          act.flag = 1'b1;
        end
      end
      MODE_WIDTH: begin
        counting = active;
        // leading edge zeroes, trailing edge captures
        if (ev_first) begin
          act.clr = 1'b1;
        end else if (ev_other) begin
          act.cap = 1'b1;
          act.flag = 1'b1;
        end
      end
      MODE_FREQ_WIDTH: begin
        counting = active & ((seq_r == ST_RUN) | (seq_r == ST_MID));
        // zero, capture width, then stop at period end
        if (ev_first && seq_r == ST_IDLE) begin
          seq_nxt = ST_RUN;
          act.clr = 1'b1;
        end else if (ev_other && seq_r == ST_RUN) begin
          seq_nxt = ST_MID;
          act.cap = 1'b1;
        end else if (ev_first && seq_r == ST_MID) begin
          seq_nxt = ST_DONE;
          act.flag = 1'b1;
        end else if (seq_r == ST_DONE && !catch_irq_flag_r) begin
          // rearm once software has taken the result
          seq_nxt = ST_IDLE;
        end
      end
      MODE_SINGLE: begin
        counting = active & (seq_r == ST_RUN);
        // any allowed edge starts one run to top
        if (seq_r == ST_IDLE && (ev_first || (cfg_r.edge_sel && ev_other)))
        begin
          seq_nxt = ST_RUN;
          act.clr = 1'b1;
        end else if (counting && top_full) begin
          seq_nxt = ST_IDLE;
          act.flag = 1'b1;
          act.clr = 1'b1;
        end
      end
      MODE_WAVE8: begin
        counting = active;
        // eight-bit period taken from the low byte
        if (active && top_low) begin
          act.flag = 1'b1;
          act.clr = 1'b1;
        end
      end
      default: begin
        counting = 1'b0;
      end
    endcase
    // disabling drops any armed sequence
    if (!cfg_r.enable) begin
      seq_nxt = ST_IDLE;
    end
  end

  // ==========================================================
  // event level history
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      evt_prev_r <= 1'b0;
    end else begin
      evt_prev_r <= i_event;
    end
  end

  // run sequence
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      seq_r <= ST_IDLE;
    end else begin
      seq_r <= seq_nxt;
    end
  end

  // ==========================================================
  // counter; a bus commit overrides the internal update
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count_value_r <= RST_WORD;
    end else if (wr_cnt_lo) begin
      count_value_r <= {latch_r, wbyte};
    end else if (act.clr) begin
      count_value_r <= RST_WORD;
    end else if (counting) begin
      count_value_r <= count_value_r + 16'h0001;
    end
  end

  // compare/capture value; bus commit wins over a capture
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      compare_capture_value_r <= RST_WORD;
    end else if (wr_compare_capture_value_lo) begin
      compare_capture_value_r <= {latch_r, wbyte};
    end else if (act.cap) begin
      compare_capture_value_r <= count_value_r;
    end
  end

  // ==========================================================
  // shared high-byte latch
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      latch_r <= RST_BYTE;
    end else if (wr_latch) begin
      latch_r <= wbyte;
    end else if (rd_load && i_avs_address == IDX_COUNT_LO) begin
      latch_r <= count_value_r[15:8];
    end else if (rd_load && i_avs_address == IDX_COMPARE_CAPTURE_VALUE_LO) begin
      latch_r <= compare_capture_value_r[15:8];
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_r <= '0;
    end else if (wr_acc) begin
      case (i_avs_address)
        IDX_CTRL_ENABLE: cfg_r.enable <= wbyte[BIT_ENABLE];
        IDX_CTRL_MODE: cfg_r.mode <= wbyte[MODE_LSB+:3];
        IDX_EVENT_CTRL: begin
          cfg_r.event_input_enable <= wbyte[BIT_EVENT_EN];
          cfg_r.edge_sel <= wbyte[BIT_EDGE];
        end
        IDX_INT_CTRL: cfg_r.irq_enable <= wbyte[BIT_CATCH];
        IDX_DEBUG_CTRL: cfg_r.debug_run <= wbyte[BIT_DEBUG_RUN];
        default: begin
          // other indexes hold no configuration
        end
      endcase
    end
  end

  // ==========================================================
  // catch flag: a set in the same cycle as a clear wins
  logic flag_clr; // any clear source this edge
  logic cap_mode; // modes whose compare read clears
  assign cap_mode = (cfg_r.mode == MODE_CAPTURE)
    | (cfg_r.mode == MODE_FREQ) | (cfg_r.mode == MODE_WIDTH)
    | (cfg_r.mode == MODE_FREQ_WIDTH);
  assign flag_clr = (wr_acc & wbyte[BIT_CATCH]
    & ((i_avs_address == IDX_INT_FLAGS)
    | (i_avs_address == IDX_INT_CLEAR)))
    | (rd_acc & cap_mode & (i_avs_address == IDX_COMPARE_CAPTURE_VALUE_LO));

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      catch_irq_flag_r <= 1'b0;
    end else if (act.flag) begin
      catch_irq_flag_r <= 1'b1;
    end else if (flag_clr) begin
      catch_irq_flag_r <= 1'b0;
    end
  end

  // interrupt level, gated by its enable
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= catch_irq_flag_r & cfg_r.irq_enable;
    end
  end

  // run status; only hardware drives it
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      run_r <= 1'b0;
    end else begin
      run_r <= counting;
    end
  end

  // ==========================================================
  // bus handshake: one wait cycle, then the answer
  // read data and the high-byte snapshot load together as it falls
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_r <= 1'b1;
    end else if (!wait_r) begin
      wait_r <= 1'b1;
    end else if (i_avs_read || i_avs_write) begin
      wait_r <= 1'b0;
    end
  end

  // read mux, loaded as waitrequest falls; unmapped reads zero
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_r <= '0;
    end else if (wait_r && i_avs_read) begin
      rdata_r <= '0;
      case (i_avs_address)
        IDX_CTRL_ENABLE: rdata_r[BIT_ENABLE] <= cfg_r.enable;
        IDX_CTRL_MODE: rdata_r[MODE_LSB+:3] <= cfg_r.mode;
        IDX_EVENT_CTRL: begin
          rdata_r[BIT_EVENT_EN] <= cfg_r.event_input_enable;
          rdata_r[BIT_EDGE] <= cfg_r.edge_sel;
        end
        IDX_INT_CTRL: rdata_r[BIT_CATCH] <= cfg_r.irq_enable;
        IDX_INT_FLAGS: rdata_r[BIT_CATCH] <= catch_irq_flag_r;
        IDX_RUN_STATUS: rdata_r[BIT_RUN] <= run_r;
        IDX_DEBUG_CTRL: rdata_r[BIT_DEBUG_RUN] <= cfg_r.debug_run;
        IDX_HIGH_LATCH: rdata_r[7:0] <= latch_r;
        IDX_COUNT_LO: rdata_r[7:0] <= count_value_r[7:0];
        IDX_COUNT_HI: rdata_r[7:0] <= latch_r;
        IDX_COMPARE_CAPTURE_VALUE_LO: rdata_r[7:0] <= compare_capture_value_r[7:0];
        IDX_COMPARE_CAPTURE_VALUE_HI: rdata_r[7:0] <= latch_r;
        default: begin
          // write-only clear and holes read as zero
        end
      endcase
    end
  end

  // ==========================================================
  // outputs
  assign o_avs_readdata = rdata_r;
  assign o_avs_waitrequest = wait_r;
  assign o_run = run_r;
  assign o_irq = irq_r;
endmodule
`default_nettype wire

//--- common/tmr_pkg.sv
// constants, register map and carrier types for the capture timer
// assumes a 32-bit avalon-mm host and word (not byte) addressing
`default_nettype none
package tmr_pkg;
  // ==========================================================
  // bus shape
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] data_t;
  typedef logic [3:0] be_t;

  // ==========================================================
  // register indexes (byte address is four times the index)
  localparam addr_t IDX_CTRL_ENABLE = 4'h0;
  localparam addr_t IDX_CTRL_MODE = 4'h1;
  localparam addr_t IDX_EVENT_CTRL = 4'h4;
  localparam addr_t IDX_INT_CTRL = 4'h5;
  localparam addr_t IDX_INT_FLAGS = 4'h6;
  localparam addr_t IDX_RUN_STATUS = 4'h7;
  localparam addr_t IDX_DEBUG_CTRL = 4'h8;
  localparam addr_t IDX_HIGH_LATCH = 4'h9;
  localparam addr_t IDX_COUNT_LO = 4'hA;
  localparam addr_t IDX_COUNT_HI = 4'hB;
  localparam addr_t IDX_COMPARE_CAPTURE_VALUE_LO = 4'hC;
  localparam addr_t IDX_COMPARE_CAPTURE_VALUE_HI = 4'hD;
  localparam addr_t IDX_INT_CLEAR = 4'hE;

  // ==========================================================
  // field positions
  localparam int BIT_ENABLE = 0;
  localparam int BIT_EVENT_EN = 0;
  localparam int BIT_EDGE = 4;
  localparam int BIT_CATCH = 0;
  localparam int BIT_RUN = 0;
  localparam int BIT_DEBUG_RUN = 0;
  localparam int MODE_LSB = 0;

  // ==========================================================
  // counter mode field codes
  localparam logic [2:0] MODE_PERIODIC = 3'h0;
  localparam logic [2:0] MODE_TIMEOUT = 3'h1;
  localparam logic [2:0] MODE_CAPTURE = 3'h2;
  localparam logic [2:0] MODE_FREQ = 3'h3;
  localparam logic [2:0] MODE_WIDTH = 3'h4;
  localparam logic [2:0] MODE_FREQ_WIDTH = 3'h5;
  localparam logic [2:0] MODE_SINGLE = 3'h6;
  localparam logic [2:0] MODE_WAVE8 = 3'h7;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // software-owned configuration, carried as one bundle
  typedef struct packed {
    logic enable;
    logic [2:0] mode;
    logic event_input_enable;
    logic edge_sel;
    logic irq_enable;
    logic debug_run;
  } cfg_t;

  // one-cycle event decode from the measurement logic
  typedef struct packed {
    logic cap;
    logic clr;
    logic flag;
  } act_t;

  // run sequence of the armed modes
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_MID, ST_DONE} seq_t;
endpackage
`default_nettype wire

//--- test/capture_timer_asserts.sv
// checker for the capture timer: bus handshake, irq gate, run, latch
// assumes it is bound into capture_timer and sees only its ports
`default_nettype none
module capture_timer_asserts #(
  parameter int CNT_W = 16 // counter width, kept in step with the design
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire tmr_pkg::addr_t i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire tmr_pkg::data_t i_avs_writedata,
  input wire tmr_pkg::be_t i_avs_byteenable,
  input wire tmr_pkg::data_t o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic i_event,
  input wire logic i_debug_halt,
  input wire logic o_run,
  input wire logic o_irq
);
  import tmr_pkg::*;
  // ==========================================================
  // shadow of the software settings
  logic take_wr; // write completes at this edge
  logic take_rd; // read completes at this edge
  logic en_r, irq_en_r, dbg_run_r; // mirrored control bits
  logic [7:0] lat_r; // expected shared latch content
  logic lat_ok_r; // low when a low-byte access made lat_r unknown
  assign take_wr = !o_avs_waitrequest && i_avs_write
    && i_avs_byteenable[0];
  assign take_rd = !o_avs_waitrequest && i_avs_read;
  // mirror updates on the very edge the design commits a write
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      en_r <= 1'b0;
      irq_en_r <= 1'b0;
      dbg_run_r <= 1'b0;
      lat_r <= 8'h00;
      lat_ok_r <= 1'b1;
    end else if (take_wr) begin
      case (i_avs_address)
        IDX_CTRL_ENABLE: en_r <= i_avs_writedata[0];
        IDX_INT_CTRL: irq_en_r <= i_avs_writedata[0];
        IDX_DEBUG_CTRL: dbg_run_r <= i_avs_writedata[0];
        IDX_HIGH_LATCH, IDX_COUNT_HI, IDX_COMPARE_CAPTURE_VALUE_HI: begin
          lat_r <= i_avs_writedata[7:0];
          lat_ok_r <= 1'b1;
        end
        // low-byte commit: latch not tracked further
        IDX_COUNT_LO, IDX_COMPARE_CAPTURE_VALUE_LO: lat_ok_r <= 1'b0;
        default: ;
      endcase
    end else if (take_rd && (i_avs_address == IDX_COUNT_LO
      || i_avs_address == IDX_COMPARE_CAPTURE_VALUE_LO)) begin
      lat_ok_r <= 1'b0; // latch now holds a live high byte
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_req;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_halted;
    i_debug_halt && !dbg_run_r;
  endsequence
  chk_ack_next: assert property (s_req |=> !o_avs_waitrequest)
    else $error("request not answered after one wait cycle");
  chk_ack_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_ack_caused: assert property (!o_avs_waitrequest
    |-> $past(i_avs_read || i_avs_write))
    else $error("answer without a request");
  chk_read_pad: assert property (take_rd
    |-> o_avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  chk_latch_read: assert property (take_rd && lat_ok_r
    && i_avs_address == IDX_HIGH_LATCH |-> o_avs_readdata[7:0] == lat_r)
    else $error("shared latch read back wrong");
  chk_irq_gate: assert property (o_irq |-> irq_en_r || $past(irq_en_r))
    else $error("irq high with irq enable off");
  chk_irq_masked: assert property (!irq_en_r [*2] |-> !o_irq)
    else $error("irq not masked");
  chk_run_off: assert property (!en_r [*3] |-> !o_run)
    else $error("run high while disabled");
  chk_halt_run: assert property (s_halted [*3] |-> !o_run)
    else $error("counter ran during debug halt");
endmodule
bind capture_timer capture_timer_asserts #(.CNT_W(CNT_W)) u_asserts (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_event(i_event), .i_debug_halt(i_debug_halt), .o_run(o_run),
  .o_irq(o_irq));
`default_nettype wire

//--- test/event_source.sv
// event network model: moves the event level after a chosen lag
// assumes the same clock as the timer, level changes at clock edges
`default_nettype none
module event_source (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_set,
  input wire logic i_level,
  input wire logic [3:0] i_lag,
  output logic o_event
);
  logic [3:0] left_r; // cycles still to wait
  logic goal_r; // level to show once the lag ran out
  logic busy_r; // a change is pending
  // ==========================================================
  // lag of zero answers promptly, larger lags model slow routing
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_event <= 1'b0;
      busy_r <= 1'b0;
      left_r <= 4'h0;
      goal_r <= 1'b0;
    end else if (i_set) begin
      goal_r <= i_level;
      left_r <= i_lag;
      busy_r <= 1'b1;
    end else if (busy_r && left_r == 4'h0) begin
      o_event <= goal_r;
      busy_r <= 1'b0;
    end else if (busy_r) begin
      left_r <= left_r - 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- test/capture_timer_tb.sv
// self-checking bench for the capture timer registers and all eight counter modes
// assumes event_source as the event network and the bound checker
`default_nettype none
module capture_timer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tmr_pkg::*;
  logic clk, arst_n, rd, wr, halt, ev_set, ev_lvl, evt, waitreq, run, irq;
  addr_t addr; // bus address
  data_t wdata, rdata; // bus data
  be_t be, be_sel; // byte enables, driven and chosen
  logic [3:0] ev_lag; // event model lag
  logic [7:0] q; // byte read back
  logic [15:0] v, c; // words read back
  int n_fail, n_tests, i;
  capture_timer #(.CNT_W(16)) dut (.i_clk(clk), .i_arst_n(arst_n),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_event(evt), .i_debug_halt(halt),
    .o_run(run), .o_irq(irq));
  event_source evs (.i_clk(clk), .i_arst_n(arst_n), .i_set(ev_set),
    .i_level(ev_lvl), .i_lag(ev_lag), .o_event(evt));
  // ==========================================================
  // clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ==========================================================
  // reporting
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ok(input logic cond);
    chk({15'h0000, cond}, 16'h0001);
  endtask
  task automatic hang;
    chk(16'h0000, 16'h0001);
    wrap_up();
  endtask
  // ==========================================================
  // bus beat: held until waitrequest is seen low, released after
  task automatic bus(input logic we, input addr_t a, input logic [7:0] d,
    output logic [7:0] r);
    int k;
    @(posedge clk);
    rd <= ~we;
    wr <= we;
    addr <= a;
    wdata <= {24'h000000, d};
    be <= be_sel;
    for (k = 0; k < 16; k++) begin
      @(posedge clk);
      if (waitreq === 1'b0) break;
    end
    if (k == 16) hang();
    r = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wr8(input addr_t a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd8(input addr_t a, output logic [7:0] r);
    bus(1'b0, a, 8'h00, r);
  endtask
  // high byte goes to the latch first, low byte commits
  task automatic w16(input addr_t a, input logic [15:0] d);
    wr8(a + 4'h1, d[15:8]);
    wr8(a, d[7:0]);
  endtask
  task automatic r16(input addr_t a, output logic [15:0] d);
    logic [7:0] lo, hi;
    rd8(a, lo);
    rd8(a + 4'h1, hi);
    d = {hi, lo};
  endtask
  task automatic ev(input logic l, input logic [3:0] g);
    @(posedge clk);
    ev_set <= 1'b1;
    ev_lvl <= l;
    ev_lag <= g;
    @(posedge clk);
    ev_set <= 1'b0;
    repeat (int'(g) + 3) @(posedge clk);
  endtask
  task automatic wait_irq;
    int k;
    for (k = 0; k < 300; k++) begin
      @(negedge clk);
      if (irq === 1'b1) break;
    end
    if (k == 300) hang();
  endtask
  // stop, drop the flag, switch mode, restart
  task automatic setmode(input logic [2:0] m);
    wr8(IDX_CTRL_ENABLE, 8'h00);
    wr8(IDX_INT_CLEAR, 8'h01);
    wr8(IDX_CTRL_MODE, {5'h00, m});
    wr8(IDX_CTRL_ENABLE, 8'h01);
  endtask
  task automatic rdchk(input addr_t a, input logic [7:0] e);
    logic [7:0] r;
    rd8(a, r);
    chk({8'h00, r}, {8'h00, e});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {arst_n, rd, wr, halt, ev_set, ev_lvl} = 6'h00;
    addr = 4'h0;
    wdata = 32'h00000000;
    be = 4'hF;
    be_sel = 4'hF;
    ev_lag = 4'h0;
    n_fail = 0;
    n_tests = 0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    for (i = 6; i < 14; i++) rdchk(addr_t'(i), 8'h00);
    wr8(4'h3, 8'hFF);
    rdchk(4'h3, 8'h00);
    wr8(IDX_HIGH_LATCH, 8'h5A);
    be_sel = 4'hE;
    wr8(IDX_HIGH_LATCH, 8'h11);
    be_sel = 4'hF;
    rdchk(IDX_HIGH_LATCH, 8'h5A);
    w16(IDX_COUNT_LO, 16'h1234);
    r16(IDX_COUNT_LO, v);
    chk(v, 16'h1234);
    w16(IDX_COMPARE_CAPTURE_VALUE_LO, 16'hBEEF);
    r16(IDX_COMPARE_CAPTURE_VALUE_LO, v);
    chk(v, 16'hBEEF);
    for (i = 0; i < 8; i++) begin
      wr8(IDX_CTRL_MODE, 8'(i));
      rdchk(IDX_CTRL_MODE, 8'(i));
    end
    $display("test map done");
    w16(IDX_COMPARE_CAPTURE_VALUE_LO, 16'h0010);
    w16(IDX_COUNT_LO, 16'h0000);
    setmode(MODE_PERIODIC);
    repeat (40) @(posedge clk);
    rdchk(IDX_INT_FLAGS, 8'h01);
    ok(irq === 1'b0);
    rdchk(IDX_RUN_STATUS, 8'h01);
    ok(run === 1'b1);
    wr8(IDX_INT_CTRL, 8'h01);
    wait_irq();
    r16(IDX_COUNT_LO, v);
    ok(v <= 16'h0010);
    wr8(IDX_DEBUG_CTRL, 8'h00);
    halt <= 1'b1;
    r16(IDX_COUNT_LO, v);
    r16(IDX_COUNT_LO, c);
    chk(c, v);
    rdchk(IDX_RUN_STATUS, 8'h00);
    ok(run === 1'b0);
    wr8(IDX_DEBUG_CTRL, 8'h01);
    r16(IDX_COUNT_LO, v);
    r16(IDX_COUNT_LO, c);
    ok(c !== v);
    halt <= 1'b0;
    wr8(IDX_CTRL_ENABLE, 8'h00);
    wr8(IDX_INT_FLAGS, 8'h01);
    rdchk(IDX_INT_FLAGS, 8'h00);
    ok(irq === 1'b0);
    wr8(IDX_RUN_STATUS, 8'h01);
    rdchk(IDX_RUN_STATUS, 8'h00);
    $display("test periodic done");
    wr8(IDX_EVENT_CTRL, 8'h01);
    for (i = 0; i < 2; i++) begin
      w16(IDX_COUNT_LO, 16'h0000);
      setmode(i == 0 ? MODE_TIMEOUT : MODE_SINGLE);
      ev(1'b1, 4'h5);
      wait_irq();
      ev(1'b0, 4'h0);
    end
    rdchk(IDX_RUN_STATUS, 8'h00);
    $display("test top done");
    wr8(IDX_EVENT_CTRL, 8'h00);
    setmode(MODE_CAPTURE);
    w16(IDX_COUNT_LO, 16'h8000);
    r16(IDX_COUNT_LO, v);
    ok(v[15:8] === 8'h80 && v[7:0] < 8'h10);
    ev(1'b1, 4'h0);
    rdchk(IDX_INT_FLAGS, 8'h00);
    ev(1'b0, 4'h0);
    wr8(IDX_EVENT_CTRL, 8'h01);
    ev(1'b1, 4'h5);
    rdchk(IDX_INT_FLAGS, 8'h01);
    r16(IDX_COMPARE_CAPTURE_VALUE_LO, v);
    r16(IDX_COUNT_LO, c);
    ok(v[15:8] === 8'h80 && c > v);
    rdchk(IDX_INT_FLAGS, 8'h00);
    setmode(MODE_FREQ);
    ev(1'b0, 4'h0);
    repeat (50) @(posedge clk);
    ev(1'b1, 4'h0);
    r16(IDX_COMPARE_CAPTURE_VALUE_LO, v);
    r16(IDX_COUNT_LO, c);
    ok(v >= 16'h0030 && c < v);
    rdchk(IDX_INT_FLAGS, 8'h00);
    setmode(MODE_WIDTH);
    ev(1'b0, 4'h0);
    ev(1'b1, 4'h0);
    repeat (40) @(posedge clk);
    ev(1'b0, 4'h0);
    r16(IDX_COMPARE_CAPTURE_VALUE_LO, v);
    r16(IDX_COUNT_LO, c);
    ok(v >= 16'h0028 && v < 16'h0040 && c > v);
    setmode(MODE_FREQ_WIDTH);
    ev(1'b1, 4'h0);
    ev(1'b0, 4'h0);
    rdchk(IDX_INT_FLAGS, 8'h00);
    ev(1'b1, 4'h0);
    rdchk(IDX_INT_FLAGS, 8'h01);
    rdchk(IDX_RUN_STATUS, 8'h00);
    $display("test capture done");
    w16(IDX_COMPARE_CAPTURE_VALUE_LO, 16'h0408);
    setmode(MODE_WAVE8);
    wait_irq();
    r16(IDX_COUNT_LO, v);
    ok(v <= 16'h0008);
    r16(IDX_COMPARE_CAPTURE_VALUE_LO, v);
    chk(v, 16'h0408);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rdchk(IDX_INT_FLAGS, 8'h00);
    ok(irq === 1'b0);
    $display("test waveform done");
    wrap_up();
  end
endmodule
`default_nettype wire
